/* File: verilog/parallel_io_controller.sv */
/*
 parallel io controller: 32 lines, software or peripheral ownership,
 output enable and data latches, glitch filter select, change detection.
 assumes pins are asynchronous to clock and a simple strobe register port.
*/
`include "pio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module parallel_io_controller
   import pio_pkg::*;
#(
   parameter line_bits_t LINE_MASK = 32'hFFFFFFFF
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // pins
   input wire logic [31:0] pin_in,
   output logic [31:0] pin_out,
   output logic [31:0] pin_oe,
   // peripherals
   input wire logic [31:0] periph_out,
   input wire logic [31:0] periph_oe,
   output logic [31:0] periph_in,
   // interrupt request to the controller
   output logic irq
);
   line_bits_t own;
   line_bits_t oe_latch;
   line_bits_t flt;
   line_bits_t od_latch;
   line_bits_t mask;
   line_bits_t chg;
   line_bits_t s1, s2, s3;
   line_bits_t level;
   line_bits_t level_prev;
   logic level_valid;
   logic [2:0] settle;
   logic settled;
   logic [3:0] fcnt [32];
   line_bits_t wbits;
   line_bits_t changed;
   logic rd_chg;

   assign wbits = wdata & LINE_MASK;
   assign rd_chg = rd && addr == `OFS_CHG_STAT;

   // three-stage synchroniser, only s2 and s3 are looked at
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // wait for the synchroniser to fill before trusting the level
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         settle <= 3'h0;
      end else if (settle != `SETTLE_CYCLES) begin
         settle <= settle + 3'h1;
      end
   end
   assign settled = (settle == `SETTLE_CYCLES);

   // filtered lines need FILTER_CYCLES stable agreements before moving
   // baseline copied from the pins, so pins high at reset are no change
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level <= '0;
         for (int i = 0; i < 32; i++) fcnt[i] <= 4'h0;
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (!settled) begin
               level[i] <= s3[i];
               fcnt[i] <= 4'h0;
            end else if (s2[i] != s3[i] || s3[i] == level[i]) begin
               fcnt[i] <= 4'h0;
            end else if (!flt[i] || fcnt[i] >= `FILTER_CYCLES) begin
               level[i] <= s3[i];
               fcnt[i] <= 4'h0;
            end else begin
               fcnt[i] <= fcnt[i] + 4'h1;
            end
         end
      end
   end

   // first sampled value after reset is a baseline, not a change
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level_prev <= '0;
         level_valid <= 1'b0;
      end else begin
         level_prev <= level;
         level_valid <= settled;
      end
   end
   assign changed = level_valid ? ((level ^ level_prev) & LINE_MASK) : '0;

   // ownership
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         own <= `RST_OWN;
      end else if (wr && addr == `OFS_OWN_SET) begin
         own <= own | wbits;
      end else if (wr && addr == `OFS_OWN_CLR) begin
         own <= own & ~wbits;
      end
   end

   // output enable latch, stored whatever the owner
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         oe_latch <= `RST_ZERO;
      end else if (wr && addr == `OFS_OE_SET) begin
         oe_latch <= oe_latch | wbits;
      end else if (wr && addr == `OFS_OE_CLR) begin
         oe_latch <= oe_latch & ~wbits;
      end
   end

   // filter select
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         flt <= `RST_ZERO;
      end else if (wr && addr == `OFS_FLT_SET) begin
         flt <= flt | wbits;
      end else if (wr && addr == `OFS_FLT_CLR) begin
         flt <= flt & ~wbits;
      end
   end

   // output data latch
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         od_latch <= `RST_ZERO;
      end else if (wr && addr == `OFS_OD_SET) begin
         od_latch <= od_latch | wbits;
      end else if (wr && addr == `OFS_OD_CLR) begin
         od_latch <= od_latch & ~wbits;
      end
   end

   // interrupt mask
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask <= `RST_ZERO;
      end else if (wr && addr == `OFS_IRQ_EN) begin
         mask <= mask | wbits;
      end else if (wr && addr == `OFS_IRQ_DIS) begin
         mask <= mask & ~wbits;
      end
   end

   // change status: a change in the read cycle survives the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         chg <= `RST_ZERO;
      end else if (rd_chg) begin
         chg <= changed;
      end else begin
         chg <= chg | changed;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |((rd_chg ? changed : (chg | changed)) & mask);
      end
   end

   // pin drivers and peripheral inputs, registered
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe <= '0;
         periph_in <= '0;
      end else begin
         pin_out <= (own & od_latch) | (~own & periph_out);
         pin_oe <= ((own & oe_latch) | (~own & periph_oe)) & LINE_MASK;
         periph_in <= level & ~own;
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (rd) begin
         unique case (addr)
            `OFS_OWN_STAT: rdata <= own & LINE_MASK;
            `OFS_OE_STAT: rdata <= oe_latch;
            `OFS_FLT_STAT: rdata <= flt;
            `OFS_OD_STAT: rdata <= od_latch;
            `OFS_LEVEL: rdata <= level & LINE_MASK;
            `OFS_IRQ_MASK: rdata <= mask;
            `OFS_CHG_STAT: rdata <= chg | changed;
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // checks
   a_own_set_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OWN_SET |=> (own & (LINE_MASK & $past(wdata))) ==
      (LINE_MASK & $past(wdata))) else $error("ownership set lost");
   a_own_clr_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OWN_CLR |=> (own & $past(wdata) & LINE_MASK) == '0)
      else $error("ownership clear lost");
   a_periph_in_zero: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 (periph_in & $past(own)) == '0) else $error("peripheral input leaks");
   a_pin_follows_latch: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 (pin_oe & $past(own)) == ($past(oe_latch) & $past(own)))
      else $error("pin enable not from latch");
   a_od_set_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OD_SET |=> (od_latch & $past(wbits)) == $past(wbits))
      else $error("data set lost");
   a_od_clr_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OD_CLR |=> (od_latch & $past(wbits)) == '0)
      else $error("data clear lost");
   a_flt_set_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_FLT_SET |=> (flt & $past(wbits)) == $past(wbits))
      else $error("filter set lost");
   a_oe_clr_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OE_CLR |=> (oe_latch & $past(wbits)) == '0)
      else $error("enable clear lost");
   a_oe_set_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OE_SET |=> (oe_latch & $past(wbits)) == $past(wbits))
      else $error("enable set lost");
   a_flt_clr_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_FLT_CLR |=> (flt & $past(wbits)) == '0)
      else $error("filter clear lost");
   a_irq_en_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_IRQ_EN |=> (mask & $past(wbits)) == $past(wbits))
      else $error("mask enable lost");
   a_irq_dis_takes: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_IRQ_DIS |=> (mask & $past(wbits)) == '0)
      else $error("mask disable lost");
   a_own_stat_reads: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == `OFS_OWN_STAT |=> rdata == ($past(own) & LINE_MASK))
      else $error("ownership status wrong");
   a_chg_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      changed != '0 |=> (chg & $past(changed)) == $past(changed))
      else $error("change lost");
   a_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
      rd_chg && changed == '0 |=> chg == '0) else $error("read did not clear");
   a_irq_masked: assert property (@(posedge clock) disable iff (!rst_n)
      mask == '0 ##1 mask == '0 |-> !irq) else $error("irq with empty mask");
   a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
      rd && addr == 8'h0C |=> rdata == '0) else $error("reserved nonzero");
   c_own_toggle: cover property (@(posedge clock) disable iff (!rst_n)
      wr && addr == `OFS_OWN_CLR ##[1:20] wr && addr == `OFS_OWN_SET);
   c_irq_fires: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
   c_read_clear: cover property (@(posedge clock) disable iff (!rst_n)
      rd_chg && chg != '0);
   c_filtered_change: cover property (@(posedge clock) disable iff (!rst_n)
      (changed & flt) != '0);
endmodule : parallel_io_controller
`default_nettype wire

/* File: pkg/pio_consts.svh */
/*
 register offsets and reset values of the parallel io controller.
 assumes byte addressing, one 32-bit word per register.
*/
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
`define OFS_OWN_SET 8'h00
`define OFS_OWN_CLR 8'h04
`define OFS_OWN_STAT 8'h08
`define OFS_OE_SET 8'h10
`define OFS_OE_CLR 8'h14
`define OFS_OE_STAT 8'h18
`define OFS_FLT_SET 8'h20
`define OFS_FLT_CLR 8'h24
`define OFS_FLT_STAT 8'h28
`define OFS_OD_SET 8'h30
`define OFS_OD_CLR 8'h34
`define OFS_OD_STAT 8'h38
`define OFS_LEVEL 8'h3C
`define OFS_IRQ_EN 8'h40
`define OFS_IRQ_DIS 8'h44
`define OFS_IRQ_MASK 8'h48
`define OFS_CHG_STAT 8'h4C
`define RST_OWN 32'h01FFFFFF
`define RST_ZERO 32'h00000000
`define FILTER_CYCLES 4'h3
`define SETTLE_CYCLES 3'h4
`endif

/* File: pkg/pio_pkg.sv */
/*
 types shared by the parallel io controller.
 assumes nothing beyond the constants header.
*/
package pio_pkg;
   typedef logic [31:0] line_bits_t;
   typedef logic [7:0] reg_addr_t;
endpackage : pio_pkg

/* File: testbench/pin_world.sv */
/*
 pads and peripherals around the io controller.
 assumes the bench sets the board level of undriven pads.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_world (
   // pads
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] ext_level,
   output logic [31:0] pin_in,
   // peripheral side
   output logic [31:0] periph_out,
   output logic [31:0] periph_oe
);
   // undriven pads follow the board, never a stale drive
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
   // peripheral drives lines 8 to 15 only
   assign periph_out = 32'h00005A00;
   assign periph_oe = 32'h0000FF00;
endmodule : pin_world
`default_nettype wire

/* File: testbench/testbench.sv */
/*
 self-checking bench of the parallel io controller.
 assumes the pin model, the package and the constants header.
*/
`include "pio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pio_pkg::*;
   logic clock, rst_n, wr, rd, irq;
   reg_addr_t addr;
   line_bits_t wdata, rdata, pin_in, pin_out, pin_oe, d;
   line_bits_t periph_out, periph_oe, periph_in, ext_level;
   int n_mismatch, n_checks;
   // line 31 left undefined to reach the masked-bit path
   parallel_io_controller #(.LINE_MASK(32'h7FFFFFFF)) parallel_io_controller_i (
      .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in), .irq(irq));
   pin_world pin_world_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .pin_in(pin_in), .periph_out(periph_out), .periph_oe(periph_oe));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic chk(input line_bits_t got, input line_bits_t exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input reg_addr_t a, input line_bits_t v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input reg_addr_t a, output line_bits_t v);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task automatic rchk(input reg_addr_t a, input line_bits_t e);
      rd_reg(a, d);
      chk(d, e);
   endtask : rchk
   task automatic test_done;
      if (n_mismatch == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic reset_values;
      repeat (8) @(posedge clock);
      ext_level <= 32'h00100000;
      repeat (8) @(posedge clock);
      rd_reg(`OFS_CHG_STAT, d);
      chk(d & 32'h00100000, 32'h00100000);
      rchk(`OFS_OWN_STAT, `RST_OWN);
      rchk(`OFS_OE_STAT, `RST_ZERO);
      rchk(`OFS_FLT_STAT, `RST_ZERO);
      rchk(`OFS_OD_STAT, `RST_ZERO);
      rchk(`OFS_IRQ_MASK, `RST_ZERO);
      rchk(8'h0C, `RST_ZERO);
      rchk(8'h80, `RST_ZERO);
      rchk(`OFS_OD_SET, `RST_ZERO);
   endtask : reset_values
   task automatic ownership;
      wr_reg(`OFS_OWN_CLR, 32'h0000FF0F);
      wr_reg(`OFS_OWN_SET, 32'h00000003);
      wr_reg(`OFS_OWN_STAT, 32'hFFFFFFFF);
      rchk(`OFS_OWN_STAT, 32'h01FF00F3);
      repeat (6) @(posedge clock);
      chk(periph_in & 32'h01FF00F3, 32'h0);
      chk(periph_in & 32'h0000FF00, 32'h00005A00);
   endtask : ownership
   // latches on peripheral lines are kept but must not reach the pads
   task automatic drive_latches;
      wr_reg(`OFS_OE_SET, 32'h8000000E);
      wr_reg(`OFS_OE_CLR, 32'h00000008);
      wr_reg(`OFS_OD_SET, 32'h0000000F);
      wr_reg(`OFS_OD_CLR, 32'h00000001);
      rchk(`OFS_OE_STAT, 32'h00000006);
      rchk(`OFS_OD_STAT, 32'h0000000E);
      chk(pin_oe & 32'h7FFFFFFF, 32'h0000FF02);
      chk(pin_out & 32'h7FFFFFFF, 32'h00005A02);
   endtask : drive_latches
   task automatic filters;
      wr_reg(`OFS_FLT_SET, 32'h800000F0);
      wr_reg(`OFS_FLT_CLR, 32'h00000030);
      rchk(`OFS_FLT_STAT, 32'h000000C0);
   endtask : filters
   task automatic changes;
      rd_reg(`OFS_CHG_STAT, d);
      rchk(`OFS_LEVEL, 32'h00105A02);
      wr_reg(`OFS_IRQ_EN, 32'h00010000);
      rchk(`OFS_IRQ_MASK, 32'h00010000);
      chk({31'h0, irq}, 32'h0);
      ext_level <= 32'h00130000;
      for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clock);
      if (irq !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
      rchk(`OFS_CHG_STAT, 32'h00030000);
      rchk(`OFS_CHG_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr_reg(`OFS_IRQ_DIS, 32'h00010000);
      rchk(`OFS_IRQ_MASK, 32'h0);
   endtask : changes
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      ext_level = 32'h0;
      n_mismatch = 0;
      n_checks = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      reset_values();
      ownership();
      drive_latches();
      filters();
      changes();
      test_done();
   end
endmodule : testbench
`default_nettype wire
